// *** hdl/lpc_pkg.sv ***
`default_nettype none
package lpc_pkg;
  // register offsets on the internal register port
  localparam logic [4:0] ADDR_ENABLE = 5'h00;
  localparam logic [4:0] ADDR_LIGHT_TIME = 5'h01;
  localparam logic [4:0] ADDR_PROX_TIME = 5'h02;
  localparam logic [4:0] ADDR_WAIT = 5'h03;
  localparam logic [4:0] ADDR_LOW_LO = 5'h04;
  localparam logic [4:0] ADDR_LOW_HI = 5'h05;
  localparam logic [4:0] ADDR_HIGH_LO = 5'h06;
  localparam logic [4:0] ADDR_HIGH_HI = 5'h07;
  localparam logic [4:0] ADDR_PERSIST = 5'h0C;
  localparam logic [4:0] ADDR_CONFIG = 5'h0D;
  localparam logic [4:0] ADDR_STATUS = 5'h13;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_TIME = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // function_enable fields
  localparam int EN_POWER_ON = 0;
  localparam int EN_LIGHT = 1;
  localparam int EN_PROX = 2;
  localparam int EN_WAIT = 3;
  localparam int EN_LIGHT_MASK = 4;
  localparam int EN_PROX_MASK = 5;
  localparam int EN_SLEEP = 6;
  localparam logic [7:0] EN_WRITABLE = 8'h7F;
  // configuration fields
  localparam int CFG_WAIT_STRETCH = 1;
  localparam logic [7:0] CFG_WRITABLE = 8'h07;
  // status fields
  localparam int ST_LIGHT_PEND = 4;
  localparam int ST_PROX_PEND = 5;
  // command byte: select bit, type field, special code
  localparam logic [2:0] CMD_SPECIAL = 3'h7;
  localparam logic [4:0] SF_CLR_PROX = 5'h05;
  localparam logic [4:0] SF_CLR_LIGHT = 5'h06;
  localparam logic [4:0] SF_CLR_BOTH = 5'h07;
  // timing: one oscillator unit is 2.73 ms
  // kept in ns so every term stays inside a 32-bit int
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_TIME_NS = 2730000;
  localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [8:0] UNIT_SPAN = 9'h100;
  localparam logic [3:0] WAIT_STRETCH_FACTOR = 4'hC;
  // one-hot cycle phases
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_PROX = 4'h2,
    PH_WAIT = 4'h4,
    PH_LIGHT = 4'h8
  } lpc_phase_t;
endpackage
`default_nettype wire

// *** hdl/lpc_cycle_ctrl.sv ***
// Behaviour
// RULE1: host writes zero to enable bit seven
// RULE2: sleep-after-interrupt clears power after interrupting cycle
// RULE3: proximity interrupts only while proximity mask set
// RULE4: light interrupts only while light mask set
// RULE5: wait enable bit turns wait timer on/off
// RULE6: proximity enable bit turns proximity phase on/off
// RULE7: light enable bit turns light converter on/off
// RULE8: power-on bit gates oscillator, timers and converters
// RULE9: light integration is 256 minus value units
// RULE10: light value zero gives 256 units
// RULE11: proximity integration uses same unit encoding
// RULE12: host should program proximity time 0xFF
// RULE13: wait units stretch twelvefold with wait_stretch
// RULE14: wait count is 256 minus value
// RULE15: host loads wait before enabling measurements
// RULE16: light interrupt when result outside window, persistent
// RULE17: thresholds are 16-bit, low byte first
// RULE18: wait_stretch lives in configuration register
// RULE19: special commands clear pending interrupts, self-clearing
// RULE20: persistence filter per light and proximity
// RULE21: equal to threshold counts as inside
// RULE22: cycle runs proximity, wait, then light
`default_nettype none
module lpc_cycle_ctrl #(
  parameter int TICK_CYCLES = lpc_pkg::UNIT_CYCLES  // clocks per 2.73 ms unit
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port behind the serial interface
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // command byte with special functions
  input wire logic i_cmd_we,
  input wire logic [7:0] i_cmd_byte,
  // converter results, same clock domain
  input wire logic [15:0] i_light_result,
  input wire logic i_prox_out_of_range,
  // converter and oscillator control
  output logic o_osc_run,
  output logic o_prox_active,
  output logic o_wait_active,
  output logic o_light_active,
  // interrupt pin, active low
  output logic o_int_n
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // refuse a unit length the divider cannot serve
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // light persistence code to required run length
  function automatic logic [5:0] light_need(input logic [3:0] code);
    if (code <= 4'h3) begin
      light_need = {2'b00, code};
    end else begin
      light_need = 6'((code - 4'h3) * 4'h5);
    end
  endfunction

  // two's-complement register value to unit count
  function automatic logic [11:0] units_of(input logic [7:0] val);
    units_of = {3'b000, lpc_pkg::UNIT_SPAN - {1'b0, val}};
  endfunction

  // registers
  logic [7:0] enable_reg;  // function_enable
  logic [7:0] light_time_reg;  // light_integration_time
  logic [7:0] prox_time_reg;  // prox_integration_time
  logic [7:0] wait_reg;  // wait_period
  logic [7:0] low_lo_reg;  // light_low_thresh_lo
  logic [7:0] low_hi_reg;  // light_low_thresh_hi
  logic [7:0] high_lo_reg;  // light_high_thresh_lo
  logic [7:0] high_hi_reg;  // light_high_thresh_hi
  logic [7:0] persist_reg;  // light and prox persistence
  logic [7:0] config_reg;  // holds wait_stretch
  logic light_pend_reg;  // sticky light interrupt
  logic prox_pend_reg;  // sticky proximity interrupt
  logic [5:0] light_run_reg;  // consecutive light out-of-range
  logic [3:0] prox_run_reg;  // consecutive prox out-of-range
  logic [TW-1:0] div_reg;  // oscillator divider
  logic [11:0] units_reg;  // units left in phase
  lpc_pkg::lpc_phase_t state_reg;
  lpc_pkg::lpc_phase_t state_next;

  // decoded controls
  logic power_on;
  logic tick;
  logic phase_end;
  logic light_out;
  logic light_fire;
  logic prox_fire;
  logic sleep_go;
  logic clr_light;
  logic clr_prox;
  logic special_cmd;
  logic [15:0] low_thresh;
  logic [15:0] high_thresh;

  assign power_on = enable_reg[lpc_pkg::EN_POWER_ON];
  assign low_thresh = {low_hi_reg, low_lo_reg};  // low byte first [RULE17]
  assign high_thresh = {high_hi_reg, high_lo_reg};  // [RULE17]
  // equal to a threshold stays inside the window [RULE21]
  assign light_out = (i_light_result < low_thresh) || (i_light_result > high_thresh);
  assign tick = power_on && (div_reg == TW'(TICK_CYCLES - 1));
  assign phase_end = tick && (units_reg == 12'h001);

  // special function decode; each clear lasts the command cycle only [RULE19]
  assign special_cmd = i_cmd_we && (i_cmd_byte[7:5] == lpc_pkg::CMD_SPECIAL);
  assign clr_prox = special_cmd && ((i_cmd_byte[4:0] == lpc_pkg::SF_CLR_PROX) ||
                    (i_cmd_byte[4:0] == lpc_pkg::SF_CLR_BOTH));  // [RULE19]
  assign clr_light = special_cmd && ((i_cmd_byte[4:0] == lpc_pkg::SF_CLR_LIGHT) ||
                     (i_cmd_byte[4:0] == lpc_pkg::SF_CLR_BOTH));  // [RULE19]

  // persistence: code zero fires every cycle, else after a run [RULE20]
  assign light_fire = o_light_active && phase_end &&
                      enable_reg[lpc_pkg::EN_LIGHT_MASK] &&  // [RULE4]
                      ((persist_reg[3:0] == 4'h0) ||
                       (light_out && (light_run_reg + 6'h01 >= light_need(persist_reg[3:0]))));
  assign prox_fire = o_prox_active && phase_end &&
                     enable_reg[lpc_pkg::EN_PROX_MASK] &&  // [RULE3]
                     ((persist_reg[7:4] == 4'h0) ||
                      (i_prox_out_of_range &&
                       ({1'b0, prox_run_reg} + 5'h01 >= {1'b0, persist_reg[7:4]})));

  // power down when a measurement phase ends with an interrupt [RULE2]
  assign sleep_go = enable_reg[lpc_pkg::EN_SLEEP] && phase_end &&
                    (((state_reg == lpc_pkg::PH_PROX) && (prox_fire || prox_pend_reg)) ||
                     ((state_reg == lpc_pkg::PH_LIGHT) && (light_fire || light_pend_reg)));

  // register writes; any host register write beats the sleep clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enable_reg <= lpc_pkg::RST_ENABLE;
      light_time_reg <= lpc_pkg::RST_TIME;
      prox_time_reg <= lpc_pkg::RST_TIME;
      wait_reg <= lpc_pkg::RST_TIME;
      low_lo_reg <= lpc_pkg::RST_ZERO;
      low_hi_reg <= lpc_pkg::RST_ZERO;
      high_lo_reg <= lpc_pkg::RST_ZERO;
      high_hi_reg <= lpc_pkg::RST_ZERO;
      persist_reg <= lpc_pkg::RST_ZERO;
      config_reg <= lpc_pkg::RST_ZERO;
    end else if (i_reg_we) begin
      unique case (i_reg_addr)
        // bit seven is not stored, host writes it as zero [RULE1]
        lpc_pkg::ADDR_ENABLE: enable_reg <= i_reg_wdata & lpc_pkg::EN_WRITABLE;
        lpc_pkg::ADDR_LIGHT_TIME: light_time_reg <= i_reg_wdata;
        lpc_pkg::ADDR_PROX_TIME: prox_time_reg <= i_reg_wdata;
        lpc_pkg::ADDR_WAIT: wait_reg <= i_reg_wdata;
        lpc_pkg::ADDR_LOW_LO: low_lo_reg <= i_reg_wdata;
        lpc_pkg::ADDR_LOW_HI: low_hi_reg <= i_reg_wdata;
        lpc_pkg::ADDR_HIGH_LO: high_lo_reg <= i_reg_wdata;
        lpc_pkg::ADDR_HIGH_HI: high_hi_reg <= i_reg_wdata;
        lpc_pkg::ADDR_PERSIST: persist_reg <= i_reg_wdata;
        lpc_pkg::ADDR_CONFIG: config_reg <= i_reg_wdata & lpc_pkg::CFG_WRITABLE;  // [RULE18]
        default: ;  // unmapped writes are dropped
      endcase
    end else if (sleep_go) begin
      enable_reg[lpc_pkg::EN_POWER_ON] <= 1'b0;  // [RULE2]
    end
  end

  // register reads, registered data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_re) begin
      unique case (i_reg_addr)
        lpc_pkg::ADDR_ENABLE: o_reg_rdata <= enable_reg;
        lpc_pkg::ADDR_LIGHT_TIME: o_reg_rdata <= light_time_reg;
        lpc_pkg::ADDR_PROX_TIME: o_reg_rdata <= prox_time_reg;
        lpc_pkg::ADDR_WAIT: o_reg_rdata <= wait_reg;
        lpc_pkg::ADDR_LOW_LO: o_reg_rdata <= low_lo_reg;
        lpc_pkg::ADDR_LOW_HI: o_reg_rdata <= low_hi_reg;
        lpc_pkg::ADDR_HIGH_LO: o_reg_rdata <= high_lo_reg;
        lpc_pkg::ADDR_HIGH_HI: o_reg_rdata <= high_hi_reg;
        lpc_pkg::ADDR_PERSIST: o_reg_rdata <= persist_reg;
        lpc_pkg::ADDR_CONFIG: o_reg_rdata <= config_reg;
        // status shows the sticky flags and the live phase
        lpc_pkg::ADDR_STATUS: o_reg_rdata <= {2'b00, prox_pend_reg, light_pend_reg, state_reg};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // oscillator divider, held at zero while power is off [RULE8]
  always_ff @(posedge i_clk) begin
    if (i_rst || !power_on) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + TW'(1);
    end
  end

  // phase sequence: proximity, optional wait, light [RULE22]
  always_comb begin
    state_next = state_reg;
    if (!power_on) begin
      state_next = lpc_pkg::PH_IDLE;  // [RULE8]
    end else begin
      unique case (state_reg)
        lpc_pkg::PH_PROX: begin
          if (!enable_reg[lpc_pkg::EN_PROX]) begin
            state_next = lpc_pkg::PH_IDLE;  // [RULE6]
          end else if (phase_end) begin
            if (enable_reg[lpc_pkg::EN_WAIT]) begin
              state_next = lpc_pkg::PH_WAIT;  // [RULE5]
            end else if (enable_reg[lpc_pkg::EN_LIGHT]) begin
              state_next = lpc_pkg::PH_LIGHT;
            end else begin
              state_next = lpc_pkg::PH_IDLE;
            end
          end
        end
        lpc_pkg::PH_WAIT: begin
          if (!enable_reg[lpc_pkg::EN_WAIT]) begin
            state_next = lpc_pkg::PH_IDLE;  // [RULE5]
          end else if (phase_end) begin
            state_next = enable_reg[lpc_pkg::EN_LIGHT] ? lpc_pkg::PH_LIGHT : lpc_pkg::PH_IDLE;
          end
        end
        lpc_pkg::PH_LIGHT: begin
          if (!enable_reg[lpc_pkg::EN_LIGHT] || phase_end) begin
            state_next = lpc_pkg::PH_IDLE;  // [RULE7]
          end
        end
        default: begin
          // idle restarts a cycle; a lone wait with nothing to measure stays idle
          if (enable_reg[lpc_pkg::EN_PROX]) begin
            state_next = lpc_pkg::PH_PROX;
          end else if (enable_reg[lpc_pkg::EN_LIGHT]) begin
            state_next = enable_reg[lpc_pkg::EN_WAIT] ? lpc_pkg::PH_WAIT : lpc_pkg::PH_LIGHT;
          end else begin
            state_next = lpc_pkg::PH_IDLE;
          end
        end
      endcase
    end
  end

  // phase register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= lpc_pkg::PH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // unit counter loaded on phase entry, counts oscillator ticks
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      units_reg <= 12'h000;
    end else if (state_next != state_reg) begin
      unique case (state_next)
        lpc_pkg::PH_PROX: units_reg <= units_of(prox_time_reg);  // [RULE11]
        lpc_pkg::PH_LIGHT: units_reg <= units_of(light_time_reg);  // [RULE9] [RULE10]
        lpc_pkg::PH_WAIT: begin
          // stretch multiplies units, so one divider serves both rates
          if (config_reg[lpc_pkg::CFG_WAIT_STRETCH]) begin
            units_reg <= 12'(units_of(wait_reg) * lpc_pkg::WAIT_STRETCH_FACTOR);  // [RULE13]
          end else begin
            units_reg <= units_of(wait_reg);  // [RULE14]
          end
        end
        default: units_reg <= 12'h000;
      endcase
    end else if (tick && (units_reg != 12'h000)) begin
      units_reg <= units_reg - 12'h001;
    end
  end

  // consecutive out-of-range runs, counted per measurement [RULE20]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      light_run_reg <= 6'h00;
      prox_run_reg <= 4'h0;
    end else begin
      if ((state_reg == lpc_pkg::PH_LIGHT) && phase_end) begin
        light_run_reg <= (light_out && !light_fire) ? light_run_reg + 6'h01 : 6'h00;
      end
      if ((state_reg == lpc_pkg::PH_PROX) && phase_end) begin
        prox_run_reg <= (i_prox_out_of_range && !prox_fire) ? prox_run_reg + 4'h1 : 4'h0;
      end
    end
  end

  // sticky interrupt flags; a new interrupt beats a same-cycle clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      light_pend_reg <= 1'b0;
      prox_pend_reg <= 1'b0;
    end else begin
      if (light_fire) begin
        light_pend_reg <= 1'b1;  // [RULE16]
      end else if (clr_light) begin
        light_pend_reg <= 1'b0;  // [RULE19]
      end
      if (prox_fire) begin
        prox_pend_reg <= 1'b1;
      end else if (clr_prox) begin
        prox_pend_reg <= 1'b0;  // [RULE19]
      end
    end
  end

  // interrupt pin and converter controls from flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_int_n <= 1'b1;
    end else begin
      o_int_n <= !(light_pend_reg || prox_pend_reg);  // [RULE16]
    end
  end

  assign o_osc_run = power_on;  // [RULE8]
  // gated by the live bits: an aborted phase must not show during its last cycle
  assign o_prox_active = power_on && enable_reg[lpc_pkg::EN_PROX] &&
                         (state_reg == lpc_pkg::PH_PROX);  // [RULE6]
  assign o_wait_active = power_on && enable_reg[lpc_pkg::EN_WAIT] &&
                         (state_reg == lpc_pkg::PH_WAIT);  // [RULE5]
  assign o_light_active = power_on && enable_reg[lpc_pkg::EN_LIGHT] &&
                          (state_reg == lpc_pkg::PH_LIGHT);  // [RULE7]

  // checks
  logic any_pend;
  assign any_pend = light_pend_reg || prox_pend_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  osc_gate_a: assert property (!power_on |-> // [RULE8]
    (!tick && !o_prox_active && !o_wait_active && !o_light_active) ##1
    (state_reg == lpc_pkg::PH_IDLE))
    else $error("phase active while power is off");
  light_gate_a: assert property (!enable_reg[lpc_pkg::EN_LIGHT] |-> !o_light_active) // [RULE7]
    else $error("light phase with light disabled");
  prox_gate_a: assert property (!enable_reg[lpc_pkg::EN_PROX] |-> !o_prox_active) // [RULE6]
    else $error("proximity phase with proximity disabled");
  wait_gate_a: assert property (o_wait_active |-> enable_reg[lpc_pkg::EN_WAIT]) // [RULE5]
    else $error("wait phase with wait disabled");
  light_mask_a: assert property ($rose(light_pend_reg) |-> // [RULE4]
    $past(enable_reg[lpc_pkg::EN_LIGHT_MASK]) && $past(o_light_active))
    else $error("light interrupt without mask");
  prox_mask_a: assert property ($rose(prox_pend_reg) |-> // [RULE3]
    $past(enable_reg[lpc_pkg::EN_PROX_MASK]) && $past(o_prox_active))
    else $error("proximity interrupt without mask");
  sleep_power_a: assert property (sleep_go && !i_reg_we |=> !power_on ##1 !o_osc_run) // [RULE2]
    else $error("no power down after interrupt");
  // the counter is loaded from the value standing at the entry edge
  light_len_a: assert property ($rose(o_light_active) |-> // [RULE9]
    units_reg == 12'd256 - {4'h0, $past(light_time_reg)})
    else $error("light integration length wrong");
  wait_len_a: assert property ($rose(o_wait_active) && // [RULE13]
    $past(config_reg[lpc_pkg::CFG_WAIT_STRETCH]) |->
    units_reg == 12'((12'd256 - {4'h0, $past(wait_reg)}) * 12'd12))
    else $error("stretched wait length wrong");
  clear_pend_a: assert property (clr_light && !light_fire |=> !light_pend_reg ##1 // [RULE19]
    (o_int_n || prox_pend_reg || light_pend_reg))
    else $error("light clear did not take effect");
  int_pin_a: assert property ($rose(any_pend) |=> !o_int_n) // [RULE16]
    else $error("interrupt pin not asserted");

  light_fire_c: cover property (light_fire ##1 !o_int_n);
  sleep_c: cover property (sleep_go ##1 !power_on);
  full_cycle_c: cover property (o_prox_active ##[1:1000] o_wait_active ##[1:1000] o_light_active);
endmodule
`default_nettype wire

// *** testbench/lpc_host_model.sv ***
`default_nettype none
// host side of the register and command ports, one strobe per access
module lpc_host_model (
  // clock
  input wire logic i_clk,
  // register port towards the device
  output logic o_reg_we,
  output logic o_reg_re,
  output logic [4:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  // command byte port
  output logic o_cmd_we,
  output logic [7:0] o_cmd_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels from time zero
  initial begin
    o_reg_we = 1'b0;
    o_reg_re = 1'b0;
    o_reg_addr = 5'h00;
    o_reg_wdata = 8'h00;
    o_cmd_we = 1'b0;
    o_cmd_byte = 8'h00;
  end

  // one write; the spare top bit of the enable byte always goes out as zero
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_wdata <= (a == lpc_pkg::ADDR_ENABLE) ? {1'b0, d[6:0]} : d;
    o_reg_we <= 1'b1;
    @(posedge i_clk);
    o_reg_we <= 1'b0;
  endtask

  // one read; data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_re <= 1'b1;
    @(posedge i_clk);
    o_reg_re <= 1'b0;
    @(posedge i_clk);
    d = i_reg_rdata;
  endtask

  // special function command byte, single strobe
  task automatic cmd(input logic [7:0] b);
    @(posedge i_clk);
    o_cmd_byte <= b;
    o_cmd_we <= 1'b1;
    @(posedge i_clk);
    o_cmd_we <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_light_prox_cycle_control.sv ***
`default_nettype none
module test_light_prox_cycle_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4; // unit shortened so 256-unit phases stay quick
  // clock, reset, converter stimulus
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] light_res = 16'h0000;
  logic prox_oor = 1'b0;
  // host model wiring
  logic reg_we, reg_re, cmd_we;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, rdata, cmd_byte, rd, rd2;
  // device outputs
  logic osc_run, prox_act, wait_act, light_act, int_n;
  // bookkeeping
  int n_fail = 0;
  int comparisons = 0;
  int c_prox, c_wait, c_light, c_int, n;

  // free-running clock
  always #5 i_clk = ~i_clk;

  lpc_cycle_ctrl #(.TICK_CYCLES(TICK)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_we(reg_we), .i_reg_re(reg_re),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .i_cmd_we(cmd_we), .i_cmd_byte(cmd_byte), .i_light_result(light_res),
    .i_prox_out_of_range(prox_oor), .o_osc_run(osc_run), .o_prox_active(prox_act),
    .o_wait_active(wait_act), .o_light_active(light_act), .o_int_n(int_n));

  lpc_host_model host (
    .i_clk(i_clk), .o_reg_we(reg_we), .o_reg_re(reg_re), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata), .o_cmd_we(cmd_we),
    .o_cmd_byte(cmd_byte));

  // single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // counts active cycles of each phase and of the interrupt pin
  task automatic watch(input int cyc);
    c_prox = 0;
    c_wait = 0;
    c_light = 0;
    c_int = 0;
    repeat (cyc) begin
      @(negedge i_clk);
      c_prox += int'(prox_act === 1'b1);
      c_wait += int'(wait_act === 1'b1);
      c_light += int'(light_act === 1'b1);
      c_int += int'(int_n === 1'b0);
    end
  endtask

  // phase output selected by index: prox, wait, light
  function automatic logic act(input int sel);
    return (sel == 0) ? prox_act : ((sel == 1) ? wait_act : light_act);
  endfunction

  // length of the next full phase; first unit may be short by divider phase
  task automatic meas(input int sel, input int units);
    int k;
    k = 0;
    // a phase entered at the edge of the last write still runs on old values
    @(negedge i_clk);
    while (act(sel) === 1'b1 && k < 5000) begin
      @(negedge i_clk);
      k++;
    end
    while (act(sel) !== 1'b1 && k < 5000) begin
      @(negedge i_clk);
      k++;
    end
    n = 0;
    while (act(sel) === 1'b1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    check(16'(n > (units - 1) * TICK && n <= units * TICK), 16'h0001);
  endtask

  // clear pending flags with the device powered down
  task automatic clear_all();
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h00);
    host.cmd(8'hE7);
    repeat (3) @(negedge i_clk);
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog, well past the expected few thousand cycles
  initial begin
    #400us;
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, unmapped read, byte order of thresholds
    for (int a = 0; a < 8; a++) begin
      host.rd(5'(a), rd);
      check({8'h00, rd}, (a >= 1 && a <= 3) ? 16'h00FF : 16'h0000);
    end
    host.rd(5'h1F, rd);
    check({8'h00, rd}, 16'h0000);
    host.wr(lpc_pkg::ADDR_LOW_LO, 8'h23);
    host.wr(lpc_pkg::ADDR_LOW_HI, 8'h01);
    host.wr(lpc_pkg::ADDR_HIGH_LO, 8'h34);
    host.wr(lpc_pkg::ADDR_HIGH_HI, 8'h02);
    host.rd(lpc_pkg::ADDR_LOW_LO, rd);
    host.rd(lpc_pkg::ADDR_LOW_HI, rd2);
    check({rd2, rd}, 16'h0123);
    host.rd(lpc_pkg::ADDR_HIGH_LO, rd);
    host.rd(lpc_pkg::ADDR_HIGH_HI, rd2);
    check({rd2, rd}, 16'h0234);
    $display("test 1 done");
    // phase lengths and order; wait loaded before enabling
    host.wr(lpc_pkg::ADDR_WAIT, 8'hFE);
    host.wr(lpc_pkg::ADDR_PROX_TIME, 8'hFF);
    host.wr(lpc_pkg::ADDR_LIGHT_TIME, 8'hFD);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h0F);
    meas(0, 1);
    check({15'h0000, wait_act}, 16'h0001);
    meas(1, 2);
    check({15'h0000, light_act}, 16'h0001);
    meas(2, 3);
    host.wr(lpc_pkg::ADDR_CONFIG, 8'h02);
    host.wr(lpc_pkg::ADDR_WAIT, 8'hFF);
    meas(1, 12);
    host.wr(lpc_pkg::ADDR_LIGHT_TIME, 8'h00);
    meas(2, 256);
    $display("test 2 done");
    // individual enables and the power gate
    host.wr(lpc_pkg::ADDR_LIGHT_TIME, 8'hFF);
    host.wr(lpc_pkg::ADDR_CONFIG, 8'h00);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h03);
    watch(60);
    check(16'(c_prox), 16'h0000);
    check(16'(c_wait), 16'h0000);
    check(16'(c_light > 0), 16'h0001);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h0E);
    watch(30);
    check(16'(c_prox + c_wait + c_light), 16'h0000);
    check({15'h0000, osc_run}, 16'h0000);
    $display("test 3 done");
    // light interrupt: mask, window edges, clear, every-cycle filter
    host.wr(lpc_pkg::ADDR_PERSIST, 8'h11);
    light_res <= 16'h0300;
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h03);
    watch(40);
    check(16'(c_int), 16'h0000);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h13);
    watch(40);
    check(16'(c_int > 0), 16'h0001);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h10);
    host.cmd(8'hE6);
    repeat (3) @(negedge i_clk);
    check({15'h0000, int_n}, 16'h0001);
    foreach (light_res[i]) begin
      if (i < 2) begin
        light_res <= (i == 0) ? 16'h0123 : 16'h0234;
        host.wr(lpc_pkg::ADDR_ENABLE, 8'h13);
        watch(40);
        check(16'(c_int), 16'h0000);
        clear_all();
      end
    end
    light_res <= 16'h0122;
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h13);
    watch(40);
    check(16'(c_int > 0), 16'h0001);
    clear_all();
    host.wr(lpc_pkg::ADDR_PERSIST, 8'h00);
    light_res <= 16'h0200;
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h13);
    watch(40);
    check(16'(c_int > 0), 16'h0001);
    clear_all();
    $display("test 4 done");
    // proximity interrupt mask, then selective and joint clears
    host.wr(lpc_pkg::ADDR_PERSIST, 8'h10);
    prox_oor <= 1'b1;
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h05);
    watch(40);
    check(16'(c_int), 16'h0000);
    host.wr(lpc_pkg::ADDR_PERSIST, 8'h11);
    light_res <= 16'h0300;
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h37);
    watch(40);
    check(16'(c_int > 0), 16'h0001);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h30);
    host.cmd(8'hE5);
    host.rd(lpc_pkg::ADDR_STATUS, rd);
    check({14'h0000, rd[5:4]}, 16'h0001);
    check({15'h0000, int_n}, 16'h0000);
    host.cmd(8'hE7);
    host.rd(lpc_pkg::ADDR_STATUS, rd);
    check({14'h0000, rd[5:4]}, 16'h0000);
    check({15'h0000, int_n}, 16'h0001);
    prox_oor <= 1'b0;
    $display("test 5 done");
    // sleep after interrupt drops the power bit
    host.wr(lpc_pkg::ADDR_PERSIST, 8'h01);
    host.wr(lpc_pkg::ADDR_ENABLE, 8'h53);
    watch(40);
    check({15'h0000, osc_run}, 16'h0000);
    host.rd(lpc_pkg::ADDR_ENABLE, rd);
    check({8'h00, rd}, 16'h0052);
    clear_all();
    $display("test 6 done");
    summarize();
  end
endmodule
`default_nettype wire
